/* common/pgr_cfg.svh */
// Constants for the pulse generator output routing block.
// Assumes a 20 MHz core clock; included by bare name wherever needed.
`ifndef PGR_CFG_SVH
`define PGR_CFG_SVH

// Channel and point counts, point index width and counter width.
`define PGR_NUM_CHAN        4
`define PGR_NUM_POINTS      12
`define PGR_ONBOARD_POINTS  8
`define PGR_POINT_W         4
`define PGR_CNT_W           16

// First absent point: on-board on the reduced variants and the full range, then past the add-on board.
`define PGR_SIX_LIMIT       4'h6
`define PGR_FOUR_LIMIT      4'h4
`define PGR_ONBOARD_LIMIT   4'h8
`define PGR_ADDON_LIMIT     4'hC

// Default pulse and direction points per channel, packed channel 3 first, then the default period and high time.
`define PGR_RST_PULSE_POINTS 16'h6420
`define PGR_RST_DIR_POINTS   16'h7531
`define PGR_RST_PERIOD       16'h03E8
`define PGR_RST_HIGH_TIME    16'h01F4

// Clock rate and frequency ceilings, in hertz.
`define PGR_CLK_HZ          20000000
`define PGR_FMAX_TOP_HZ     1000000
`define PGR_FMAX_BASE_HZ    100000
`define PGR_FMAX_STD_HZ     20000
`define PGR_FMAX_FAST_HZ    200000

// Shortest pulse period in clock cycles, rounded up.
`define PGR_MIN_CYC_TOP  ((`PGR_CLK_HZ + `PGR_FMAX_TOP_HZ - 1) / `PGR_FMAX_TOP_HZ)
`define PGR_MIN_CYC_BASE ((`PGR_CLK_HZ + `PGR_FMAX_BASE_HZ - 1) / `PGR_FMAX_BASE_HZ)
`define PGR_MIN_CYC_STD  ((`PGR_CLK_HZ + `PGR_FMAX_STD_HZ - 1) / `PGR_FMAX_STD_HZ)
`define PGR_MIN_CYC_FAST ((`PGR_CLK_HZ + `PGR_FMAX_FAST_HZ - 1) / `PGR_FMAX_FAST_HZ)

`endif

/* common/pgr_pkg.sv */
// Types shared by the pulse generator output routing block.
// Assumes nothing beyond a SystemVerilog compiler.
package pgr_pkg;

  // Hardware variant of the controller.
  typedef enum logic [1:0] {
    PGR_VAR_TOP,
    PGR_VAR_FULL,
    PGR_VAR_SIX,
    PGR_VAR_FOUR
  } pgr_variant_t;

  // Fitted add-on output board.
  typedef enum logic [1:0] {
    PGR_BOARD_NONE,
    PGR_BOARD_STD,
    PGR_BOARD_FAST
  } pgr_board_t;

  // Generator mode.
  typedef enum logic {
    PGR_MODE_PWM,
    PGR_MODE_TRAIN
  } pgr_mode_t;

  // Generator state.
  typedef enum logic {
    PGR_GEN_IDLE,
    PGR_GEN_RUN
  } pgr_gen_state_t;

endpackage

/* verilog/pgr_pulse_gen.sv */
// One pulse generator channel: width modulation or pulse train with direction.
// Assumes the period is already clamped to at least the legal minimum.
`timescale 1ns/10ps
`include "pgr_cfg.svh"
module pgr_pulse_gen (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  clockEnable,
  input  wire logic                  run,
  input  wire pgr_pkg::pgr_mode_t    mode,
  input  wire logic [`PGR_CNT_W-1:0] period,
  input  wire logic [`PGR_CNT_W-1:0] highTime,
  input  wire logic                  dirIn,
  output logic                       pulseOut,
  output logic                       dirOut
);
  import pgr_pkg::*;

  pgr_gen_state_t        state;
  logic [`PGR_CNT_W-1:0] count;
  logic [`PGR_CNT_W-1:0] next_count;
  logic                  next_pulse;

  // The generator only runs while allowed; it restarts its period cleanly.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= PGR_GEN_IDLE;
    end else if (clockEnable) begin
      case (state)
        PGR_GEN_IDLE: if (run) state <= PGR_GEN_RUN;
        PGR_GEN_RUN:  if (!run) state <= PGR_GEN_IDLE;
        default:      state <= PGR_GEN_IDLE;
      endcase
    end
  end

  // Period counter and waveform decision; a train runs at half duty.
  always_comb begin
    next_count = count + 16'h0001;
    if (count >= period - 16'h0001) begin
      next_count = 16'h0000;
    end
    if (mode == PGR_MODE_PWM) begin
      next_pulse = (next_count < highTime);
    end else begin
      next_pulse = (next_count < (period >> 1));
    end
  end

  // Outputs come from flops so the pins see no glitches.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count    <= 16'h0000;
      pulseOut <= 1'b0;
      dirOut   <= 1'b0;
    end else if (clockEnable) begin
      if (state == PGR_GEN_RUN && run) begin
        count    <= next_count;
        pulseOut <= next_pulse;
        dirOut   <= (mode == PGR_MODE_TRAIN) ? dirIn : 1'b0;
      end else begin
        count    <= 16'hFFFF; // First running edge wraps to zero.
        pulseOut <= 1'b0;
        dirOut   <= 1'b0;
      end
    end
  end
endmodule

/* verilog/pgr_point_select.sv */
// Per-point output selector: generator signal when claimed, image bit otherwise.
// Assumes claim flags are already checked for presence of the point.
`timescale 1ns/10ps
`include "pgr_cfg.svh"
module pgr_point_select (
  input  wire logic                                         clock,
  input  wire logic                                         reset_n,
  input  wire logic                                         clockEnable,
  input  wire logic [`PGR_NUM_CHAN-1:0][`PGR_POINT_W-1:0]   pulsePoint,
  input  wire logic [`PGR_NUM_CHAN-1:0][`PGR_POINT_W-1:0]   dirPoint,
  input  wire logic [`PGR_NUM_CHAN-1:0]                     pulseClaim,
  input  wire logic [`PGR_NUM_CHAN-1:0]                     dirClaim,
  input  wire logic [`PGR_NUM_CHAN-1:0]                     genPulse,
  input  wire logic [`PGR_NUM_CHAN-1:0]                     genDir,
  input  wire logic [`PGR_NUM_POINTS-1:0]                   imageBits,
  output logic      [`PGR_NUM_POINTS-1:0]                   pointOut,
  output logic      [`PGR_NUM_POINTS-1:0]                   pointOwned
);
  import pgr_pkg::*;

  genvar p;
  generate
    for (p = 0; p < `PGR_NUM_POINTS; p = p + 1) begin : g_point
      logic owned;
      logic value;

      // Lower channel numbers win if two channels name the same point.
      always_comb begin
        owned = 1'b0;
        value = imageBits[p];
        for (int c = `PGR_NUM_CHAN - 1; c >= 0; c--) begin
          if (dirClaim[c] && dirPoint[c] == `PGR_POINT_W'(p)) begin
            owned = 1'b1;
            value = genDir[c];
          end
          if (pulseClaim[c] && pulsePoint[c] == `PGR_POINT_W'(p)) begin
            owned = 1'b1;
            value = genPulse[c];
          end
        end
      end

      // Registered pin drive and ownership flag.
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          pointOut[p]   <= 1'b0;
          pointOwned[p] <= 1'b0;
        end else if (clockEnable) begin
          pointOut[p]   <= value;
          pointOwned[p] <= owned;
        end
      end
    end
  endgenerate
endmodule

/* verilog/pgr_route.sv */
// Top of the pulse generator output routing block.
// Assumes configuration and program image come from logic on the same clock.
`timescale 1ns/10ps
`include "pgr_cfg.svh"

// Notes on behaviour
// - There are four independent generators routable to on-board or add-on board outputs.
// - Each generator runs in exactly one mode, width modulation or pulse train.
// - A point claimed by a generator is removed from the program's view of the output image.
// - Program writes to a claimed point are ignored and the generator keeps the pin.
// - On-board pulses are limited to 1 MHz on the top variant and 100 KHz otherwise, without a flag.
// - Add-on board pulses are limited to 20 KHz on a standard board and 200 KHz on a fast one.
// - A generator may use any on-board or add-on point and never an expansion or remote point.
// - Width mode drives one output; train mode drives a pulse and an optional direction output.
// - Any point not used by a pulse function stays an ordinary program output.
// - By default generators are off, set to points 0, 2, 4, 6 with direction on the next odd point.
// - Points absent on a reduced variant can never be claimed by a generator.
// - Ordinary points take the program image at the start of each scan.
// - Configuration is accepted at any time but pulses run only in run mode.
module pgr_route (
  input  wire logic                                       clock,
  input  wire logic                                       reset_n,
  input  wire logic                                       clockEnable,
  input  wire logic                                       runMode,
  input  wire pgr_pkg::pgr_variant_t                      hwVariant,
  input  wire pgr_pkg::pgr_board_t                        boardType,
  input  wire logic [`PGR_NUM_CHAN-1:0]                   cfgLoad,
  input  wire logic [`PGR_NUM_CHAN-1:0]                   cfgEnable,
  input  wire logic [`PGR_NUM_CHAN-1:0]                   cfgTrainMode,
  input  wire logic [`PGR_NUM_CHAN-1:0]                   cfgDirEnable,
  input  wire logic [`PGR_NUM_CHAN-1:0][`PGR_POINT_W-1:0] cfgPulsePoint,
  input  wire logic [`PGR_NUM_CHAN-1:0][`PGR_POINT_W-1:0] cfgDirPoint,
  input  wire logic [`PGR_NUM_CHAN-1:0][`PGR_CNT_W-1:0]   cfgPeriod,
  input  wire logic [`PGR_NUM_CHAN-1:0][`PGR_CNT_W-1:0]   cfgHighTime,
  input  wire logic [`PGR_NUM_CHAN-1:0]                   dirCommand,
  input  wire logic                                       scanStart,
  input  wire logic [`PGR_NUM_POINTS-1:0]                 imageData,
  output logic      [`PGR_NUM_POINTS-1:0]                 pointOut,
  output logic      [`PGR_NUM_POINTS-1:0]                 pointOwned,
  output logic      [`PGR_NUM_POINTS-1:0]                 imageView,
  output logic      [`PGR_NUM_CHAN-1:0]                   chanActive
);
  import pgr_pkg::*;

  // Per-channel configuration, loaded by a strobe per channel.
  logic      [`PGR_NUM_CHAN-1:0]                   chanEnable;
  pgr_mode_t                                       chanMode [`PGR_NUM_CHAN];
  logic      [`PGR_NUM_CHAN-1:0]                   chanDirEnable;
  logic      [`PGR_NUM_CHAN-1:0][`PGR_POINT_W-1:0] chanPulsePoint;
  logic      [`PGR_NUM_CHAN-1:0][`PGR_POINT_W-1:0] chanDirPoint;
  logic      [`PGR_NUM_CHAN-1:0][`PGR_CNT_W-1:0]   chanPeriod;
  logic      [`PGR_NUM_CHAN-1:0][`PGR_CNT_W-1:0]   chanHighTime;
  logic      [`PGR_NUM_CHAN-1:0][`PGR_CNT_W-1:0]   effPeriod;
  logic      [`PGR_NUM_CHAN-1:0]                   pulseClaim;
  logic      [`PGR_NUM_CHAN-1:0]                   dirClaim;
  logic      [`PGR_NUM_CHAN-1:0]                   genPulse;
  logic      [`PGR_NUM_CHAN-1:0]                   genDir;
  logic      [`PGR_NUM_POINTS-1:0]                 imageLatched;
  logic      [`PGR_NUM_POINTS-1:0]                 ownedNext;

  localparam logic [`PGR_NUM_CHAN*`PGR_POINT_W-1:0] RST_PULSE = `PGR_RST_PULSE_POINTS;
  localparam logic [`PGR_NUM_CHAN*`PGR_POINT_W-1:0] RST_DIR   = `PGR_RST_DIR_POINTS;
  localparam logic [`PGR_CNT_W-1:0] MIN_TOP  = `PGR_CNT_W'(`PGR_MIN_CYC_TOP);
  localparam logic [`PGR_CNT_W-1:0] MIN_BASE = `PGR_CNT_W'(`PGR_MIN_CYC_BASE);
  localparam logic [`PGR_CNT_W-1:0] MIN_STD  = `PGR_CNT_W'(`PGR_MIN_CYC_STD);
  localparam logic [`PGR_CNT_W-1:0] MIN_FAST = `PGR_CNT_W'(`PGR_MIN_CYC_FAST);

  // A point exists only on the controller or a fitted add-on board.
  // Index values past the add-on board would be expansion or remote points.
  function automatic logic pointPresent(
    input logic [`PGR_POINT_W-1:0] point,
    input pgr_variant_t            variant,
    input pgr_board_t              board
  );
    logic present;
    present = 1'b0;
    if (point < `PGR_ONBOARD_LIMIT) begin
      case (variant)
        PGR_VAR_FOUR: present = (point < `PGR_FOUR_LIMIT);
        PGR_VAR_SIX:  present = (point < `PGR_SIX_LIMIT);
        default:      present = 1'b1;
      endcase
    end else if (point < `PGR_ADDON_LIMIT) begin
      present = (board != PGR_BOARD_NONE);
    end
    return present;
  endfunction

  // Shortest legal pulse period for the point that carries the pulse.
  function automatic logic [`PGR_CNT_W-1:0] minPeriod(
    input logic [`PGR_POINT_W-1:0] point,
    input pgr_variant_t            variant,
    input pgr_board_t              board
  );
    logic [`PGR_CNT_W-1:0] limit;
    if (point < `PGR_ONBOARD_LIMIT) begin
      limit = (variant == PGR_VAR_TOP) ? MIN_TOP : MIN_BASE;
    end else begin
      limit = (board == PGR_BOARD_FAST) ? MIN_FAST : MIN_STD;
    end
    return limit;
  endfunction

  genvar c;
  generate
    for (c = 0; c < `PGR_NUM_CHAN; c = c + 1) begin : g_chan
      // Configuration may change in startup as well as in run mode.
      // Reset leaves every channel off on its default points.
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          chanEnable[c]     <= 1'b0;
          chanMode[c]       <= PGR_MODE_PWM;
          chanDirEnable[c]  <= 1'b0;
          chanPulsePoint[c] <= RST_PULSE[c*`PGR_POINT_W +: `PGR_POINT_W];
          chanDirPoint[c]   <= RST_DIR[c*`PGR_POINT_W +: `PGR_POINT_W];
          chanPeriod[c]     <= `PGR_RST_PERIOD;
          chanHighTime[c]   <= `PGR_RST_HIGH_TIME;
        end else if (clockEnable && cfgLoad[c]) begin
          chanEnable[c]     <= cfgEnable[c];
          chanMode[c]       <= cfgTrainMode[c] ? PGR_MODE_TRAIN : PGR_MODE_PWM;
          chanDirEnable[c]  <= cfgDirEnable[c];
          chanPulsePoint[c] <= cfgPulsePoint[c];
          chanDirPoint[c]   <= cfgDirPoint[c];
          chanPeriod[c]     <= cfgPeriod[c];
          chanHighTime[c]   <= cfgHighTime[c];
        end
      end

      // Claims are made only on present points; a rejected direction claim leaves
      // that point to the program; a rejected pulse claim stops the generator, but an enabled direction point that is present stays claimed and held low.
      always_comb begin
        pulseClaim[c] = chanEnable[c] &&
                        pointPresent(chanPulsePoint[c], hwVariant, boardType);
        dirClaim[c]   = chanEnable[c] && chanMode[c] == PGR_MODE_TRAIN &&
                        chanDirEnable[c] && chanDirPoint[c] != chanPulsePoint[c] &&
                        pointPresent(chanDirPoint[c], hwVariant, boardType);
      end

      // Clamp the period silently; no error is raised for an over-fast setting.
      // The trade-off is that a too-short period just runs at the ceiling.
      always_comb begin
        effPeriod[c] = chanPeriod[c];
        if (chanPeriod[c] < minPeriod(chanPulsePoint[c], hwVariant, boardType)) begin
          effPeriod[c] = minPeriod(chanPulsePoint[c], hwVariant, boardType);
        end
      end

      // One generator per channel, each independent of the others.
      pgr_pulse_gen u_gen (
        .clock       (clock),
        .reset_n     (reset_n),
        .clockEnable (clockEnable),
        .run         (runMode && pulseClaim[c]),
        .mode        (chanMode[c]),
        .period      (effPeriod[c]),
        .highTime    (chanHighTime[c]),
        .dirIn       (dirCommand[c]),
        .pulseOut    (genPulse[c]),
        .dirOut      (genDir[c])
      );

      // Active means configured, on a real point, and in run mode.
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          chanActive[c] <= 1'b0;
        end else if (clockEnable) begin
          chanActive[c] <= runMode && pulseClaim[c];
        end
      end
    end
  endgenerate

  // The program image reaches the ordinary points only at scan start.
  // Claimed bits are held here too, but the selector never looks at them.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      imageLatched <= 12'h000;
    end else if (clockEnable && scanStart) begin
      imageLatched <= imageData;
    end
  end

  // Ownership as the selector is about to register it. Masking with the registered
  // flag instead would let the view lag the pins by one edge on every claim change.
  always_comb begin
    ownedNext = 12'h000;
    for (int p = 0; p < `PGR_NUM_POINTS; p++) begin
      for (int k = 0; k < `PGR_NUM_CHAN; k++) begin
        if ((pulseClaim[k] && chanPulsePoint[k] == `PGR_POINT_W'(p)) ||
            (dirClaim[k] && chanDirPoint[k] == `PGR_POINT_W'(p))) begin
          ownedNext[p] = 1'b1;
        end
      end
    end
  end

  // Program view of the image with claimed points taken away.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      imageView <= 12'h000;
    end else if (clockEnable) begin
      imageView <= imageLatched & ~ownedNext;
    end
  end

  // Per-point multiplexer onto the output pins.
  pgr_point_select u_select (
    .clock       (clock),
    .reset_n     (reset_n),
    .clockEnable (clockEnable),
    .pulsePoint  (chanPulsePoint),
    .dirPoint    (chanDirPoint),
    .pulseClaim  (pulseClaim),
    .dirClaim    (dirClaim),
    .genPulse    (genPulse),
    .genDir      (genDir),
    .imageBits   (imageLatched),
    .pointOut    (pointOut),
    .pointOwned  (pointOwned)
  );
endmodule

/* dv/pgr_route_sva.sv */
// Concurrent checks on the pins of the pulse output routing block.
// Assumes variant and board only change while reset is held low.
`timescale 1ns/10ps
`include "pgr_cfg.svh"
module pgr_route_sva (
  input wire logic                                       clock,
  input wire logic                                       reset_n,
  input wire logic                                       clockEnable,
  input wire logic                                       runMode,
  input wire pgr_pkg::pgr_variant_t                      hwVariant,
  input wire pgr_pkg::pgr_board_t                        boardType,
  input wire logic [`PGR_NUM_CHAN-1:0]                   cfgLoad,
  input wire logic [`PGR_NUM_CHAN-1:0]                   cfgEnable,
  input wire logic [`PGR_NUM_CHAN-1:0][`PGR_POINT_W-1:0] cfgPulsePoint,
  input wire logic                                       scanStart,
  input wire logic [`PGR_NUM_POINTS-1:0]                 imageData,
  input wire logic [`PGR_NUM_POINTS-1:0]                 pointOut,
  input wire logic [`PGR_NUM_POINTS-1:0]                 pointOwned,
  input wire logic [`PGR_NUM_POINTS-1:0]                 imageView,
  input wire logic [`PGR_NUM_CHAN-1:0]                   chanActive
);
  import pgr_pkg::*;

  // All checks share one clock; reset disables them.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Absent points are never handed to a generator.
  six_absent_a: assert property (hwVariant == PGR_VAR_SIX |-> pointOwned[7:6] == 2'h0)
    else $error("missing point claimed on six-point variant");
  four_absent_a: assert property (hwVariant == PGR_VAR_FOUR |-> pointOwned[7:4] == 4'h0)
    else $error("missing point claimed on four-point variant");
  board_absent_a: assert property (boardType == PGR_BOARD_NONE |-> pointOwned[11:8] == 4'h0)
    else $error("add-on point claimed with no board fitted");

  // Owned points never show through to the program view.
  view_mask_a: assert property ((imageView & pointOwned) == 12'h000)
    else $error("owned point visible in image view");

  // A free point carries exactly what the program view holds.
  free_pin_a: assert property (((pointOut ^ imageView) & ~pointOwned) == 12'h000)
    else $error("free pin differs from image");

  // A scan lands on the view two edges after it is taken.
  scan_capture_a: assert property ((clockEnable && scanStart) ##1 clockEnable |=>
    imageView == ($past(imageData, 2) & ~pointOwned))
    else $error("scan image not captured");

  // Channel zero always wins its claim of a low point.
  claim_chan0_a: assert property ((clockEnable && cfgLoad[0] && cfgEnable[0] && cfgPulsePoint[0] < 4'h4)
    ##1 clockEnable |=> pointOwned[$past(cfgPulsePoint[0], 2)])
    else $error("channel zero claim not taken");

  // Outside run mode the claimed pins settle low and no channel stays active.
  idle_pins_a: assert property ((clockEnable && !runMode) [*4] |-> (pointOut & pointOwned) == 12'h000)
    else $error("claimed pin active outside run mode");
  stop_inactive_a: assert property ((clockEnable && !runMode) [*3] |-> chanActive == 4'h0)
    else $error("channel active outside run mode");

  // A held clock enable freezes every output.
  freeze_state_a: assert property (!clockEnable |=> $stable(pointOut) && $stable(pointOwned)
    && $stable(imageView) && $stable(chanActive))
    else $error("outputs moved while frozen");

  // Main scenarios reached.
  all_busy_c: cover property (pointOwned[7:0] == 8'hFF);
  board_claim_c: cover property (pointOwned[11:8] != 4'h0);
  run_start_c: cover property (chanActive != 4'h0);
endmodule

bind pgr_route pgr_route_sva sva (.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable),
  .runMode(runMode), .hwVariant(hwVariant), .boardType(boardType), .cfgLoad(cfgLoad),
  .cfgEnable(cfgEnable), .cfgPulsePoint(cfgPulsePoint), .scanStart(scanStart), .imageData(imageData),
  .pointOut(pointOut), .pointOwned(pointOwned), .imageView(imageView), .chanActive(chanActive));

/* dv/pgr_drive_model.sv */
// Passive model of the drive electronics listening on one output pin.
// Assumes the pins are registered on the same clock as the model.
`timescale 1ns/10ps
module pgr_drive_model (
  input  wire logic        clock,
  input  wire logic [11:0] pins,
  input  wire logic [3:0]  watchPoint,
  input  wire logic        clearStats,
  output int               riseCount,
  output int               minGap
);
  logic prevPin;
  int   sinceRise;

  // Count rising edges and keep the shortest spacing, as a drive input stage would see them.
  always_ff @(posedge clock) begin
    prevPin <= pins[watchPoint];
    sinceRise <= sinceRise + 1;
    if (clearStats) begin
      riseCount <= 0;
      minGap <= 32'h7FFFFFFF;
      sinceRise <= 0;
    end else if (pins[watchPoint] && !prevPin) begin
      riseCount <= riseCount + 1;
      sinceRise <= 1;
      // The first edge has no predecessor, so it sets no spacing.
      if (riseCount > 0 && sinceRise < minGap) minGap <= sinceRise;
    end
  end
endmodule

/* dv/pgr_route_test.sv */
// Self-checking bench for the pulse output routing block.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
`include "pgr_cfg.svh"
module pgr_route_test;
  import pgr_pkg::*;
  logic              clock = 1'b0;
  logic              reset_n = 1'b0;
  logic              clockEnable = 1'b1;
  logic              runMode = 1'b0;
  pgr_variant_t      hwVariant = PGR_VAR_FULL;
  pgr_board_t        boardType = PGR_BOARD_NONE;
  logic [3:0]        cfgLoad = 4'h0;
  logic [3:0]        cfgEnable = 4'h0;
  logic [3:0]        cfgTrainMode = 4'h0;
  logic [3:0]        cfgDirEnable = 4'h0;
  logic [3:0][3:0]   cfgPulsePoint = '0;
  logic [3:0][3:0]   cfgDirPoint = '0;
  logic [3:0][15:0]  cfgPeriod = '0;
  logic [3:0][15:0]  cfgHighTime = '0;
  logic [3:0]        dirCommand = 4'h0;
  logic              scanStart = 1'b0;
  logic [11:0]       imageData = 12'h000;
  logic [11:0]       pointOut;
  logic [11:0]       pointOwned;
  logic [11:0]       imageView;
  logic [3:0]        chanActive;
  logic [3:0]        watchPoint = 4'h0;
  logic              clearStats = 1'b1;
  int                riseCount;
  int                minGap;
  int                err_total = 0;
  int                comparisons = 0;
  int                gapMin;
  // Claim table: variant, board, point and whether the claim must hold.
  pgr_variant_t      tabVar [8] = '{PGR_VAR_SIX, PGR_VAR_FOUR, PGR_VAR_FOUR, PGR_VAR_FULL,
                                    PGR_VAR_FULL, PGR_VAR_TOP, PGR_VAR_TOP, PGR_VAR_TOP};
  pgr_board_t        tabBrd [8] = '{PGR_BOARD_NONE, PGR_BOARD_NONE, PGR_BOARD_NONE, PGR_BOARD_NONE,
                                    PGR_BOARD_STD, PGR_BOARD_FAST, PGR_BOARD_FAST, PGR_BOARD_NONE};
  logic [3:0]        tabPt  [8] = '{4'h6, 4'h4, 4'h3, 4'h8, 4'h8, 4'hB, 4'hC, 4'h1};
  logic              tabOk  [8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

  pgr_route dut (.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable), .runMode(runMode),
    .hwVariant(hwVariant), .boardType(boardType), .cfgLoad(cfgLoad), .cfgEnable(cfgEnable),
    .cfgTrainMode(cfgTrainMode), .cfgDirEnable(cfgDirEnable), .cfgPulsePoint(cfgPulsePoint),
    .cfgDirPoint(cfgDirPoint), .cfgPeriod(cfgPeriod), .cfgHighTime(cfgHighTime), .dirCommand(dirCommand),
    .scanStart(scanStart), .imageData(imageData), .pointOut(pointOut), .pointOwned(pointOwned),
    .imageView(imageView), .chanActive(chanActive));
  pgr_drive_model drive (.clock(clock), .pins(pointOut), .watchPoint(watchPoint),
    .clearStats(clearStats), .riseCount(riseCount), .minGap(minGap));

  // Clock at 20 MHz.
  always #25 clock = ~clock;

  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // What the program sees, and what a free pin shows, once owned points are taken out.
  function automatic logic [11:0] exp_view(input logic [11:0] img, input logic [11:0] owned);
    return img & ~owned;
  endfunction

  // Shortest legal pulse spacing in clock cycles for where the pulse lands.
  function automatic int exp_min(input pgr_variant_t v, input pgr_board_t b, input logic [3:0] p);
    if (p < 4'h8) return (v == PGR_VAR_TOP) ? `PGR_MIN_CYC_TOP : `PGR_MIN_CYC_BASE;
    return (b == PGR_BOARD_STD) ? `PGR_MIN_CYC_STD : `PGR_MIN_CYC_FAST;
  endfunction

  // Reset for three cycles with the variant and board held steady meanwhile.
  task automatic do_reset(input pgr_variant_t v, input pgr_board_t b);
    @(negedge clock);
    reset_n = 1'b0;
    runMode = 1'b0;
    hwVariant = v;
    boardType = b;
    cycles(3);
    reset_n = 1'b1;
    chk(pointOut === 12'h000 && pointOwned === 12'h000 && imageView === 12'h000, "reset outputs");
  endtask

  // Load one enabled channel; the high time is half the period.
  task automatic cfg(input int c, input logic tr, input logic [3:0] pp, input logic [3:0] dp,
                     input logic [15:0] per);
    @(negedge clock);
    cfgEnable[c] = 1'b1;
    cfgTrainMode[c] = tr;
    cfgDirEnable[c] = 1'b1;
    cfgPulsePoint[c] = pp;
    cfgDirPoint[c] = dp;
    cfgPeriod[c] = per;
    cfgHighTime[c] = per >> 1;
    cfgLoad[c] = 1'b1;
    @(negedge clock);
    cfgLoad[c] = 1'b0;
  endtask

  // Random program images while idle: owned pins stay low whatever is written.
  task automatic scan_check(input logic [11:0] owned);
    logic [11:0] img;
    repeat (6) begin
      img = 12'($urandom);
      @(negedge clock);
      imageData = img;
      scanStart = 1'b1;
      @(negedge clock);
      scanStart = 1'b0;
      cycles(3);
      chk(imageView === exp_view(img, owned), "image view");
      chk(pointOut === exp_view(img, owned), "pin image");
    end
  endtask

  // Main sequence.
  initial begin
    void'($urandom(58903));
    do_reset(PGR_VAR_FULL, PGR_BOARD_NONE);
    for (int c = 0; c < 4; c++) cfg(c, 1'b1, 4'(2 * c), 4'(2 * c + 1), 16'h03E8);
    cycles(3);
    chk(pointOwned === 12'h0FF, "train owners");
    scan_check(12'h0FF);
    for (int c = 0; c < 4; c++) cfg(c, 1'b0, 4'(2 * c), 4'(2 * c + 1), 16'h03E8);
    cycles(3);
    chk(pointOwned === 12'h055, "width owners");
    scan_check(12'h055);
    // Claims per variant and board, then the pulse rate for every legal one.
    for (int i = 0; i < 8; i++) begin
      do_reset(tabVar[i], tabBrd[i]);
      gapMin = exp_min(tabVar[i], tabBrd[i], tabPt[i]);
      cfg(0, 1'b0, tabPt[i], 4'hF, 16'(2 + $urandom % (gapMin - 2)));
      cycles(3);
      chk(pointOwned === (tabOk[i] ? 12'h001 << tabPt[i] : 12'h000), "claim");
      if (tabOk[i]) begin
        watchPoint = tabPt[i];
        runMode = 1'b1;
        cycles(4);
        clearStats = 1'b0;
        cycles(6 * gapMin);
        chk(chanActive === 4'h1, "active");
        chk(riseCount >= 4 && minGap == gapMin, "pulse rate");
        runMode = 1'b0;
        clearStats = 1'b1;
        cycles(4);
        clearStats = 1'b0;
        cycles(300);
        chk(riseCount == 0 && chanActive === 4'h0, "stopped");
        clearStats = 1'b1;
      end
    end
    // Direction follows the command live; a held enable freezes it.
    do_reset(PGR_VAR_FULL, PGR_BOARD_NONE);
    cfg(0, 1'b1, 4'h0, 4'h1, 16'h03E8);
    runMode = 1'b1;
    for (int k = 0; k < 6; k++) begin
      dirCommand = 4'($urandom);
      cycles(3);
      chk(pointOut[1] === dirCommand[0], "direction pin");
    end
    clockEnable = 1'b0;
    dirCommand = ~dirCommand;
    cycles(4);
    chk(pointOut[1] === ~dirCommand[0], "frozen pin");
    clockEnable = 1'b1;
    cycles(3);
    chk(pointOut[1] === dirCommand[0], "thawed pin");
    stop_test();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    stop_test();
  end
endmodule
